// file: hdl/tsc_pkg.sv
// Shared constants and types of the trigger sequencer control block
package tsc_pkg;
  // Register byte offsets on the Avalon-MM slave
  localparam logic [5:0] OFS_CST = 6'h00;
  localparam logic [5:0] OFS_SDLIM = 6'h04;
  localparam logic [5:0] OFS_CLIM = 6'h08;
  localparam logic [5:0] OFS_TLIM = 6'h0C;
  localparam logic [5:0] OFS_PWIDTH = 6'h10;
  localparam logic [5:0] OFS_CMD = 6'h14;
  localparam logic [5:0] OFS_ISTAT = 6'h18;
  localparam logic [5:0] OFS_IMASK = 6'h1C;
  localparam logic [5:0] OFS_WDLIM = 6'h20;
  // Control/status field positions
  localparam int BIT_EN = 15;
  localparam int BIT_SIDL = 13;
  localparam int BIT_TOGL = 12;
  localparam int BIT_SWT = 10;
  localparam int BIT_SSEN = 9;
  localparam int BIT_VIS = 8;
  localparam int BIT_STRT = 7;
  localparam int BIT_WDTO = 6;
  localparam int BIT_ITM_HI = 1;
  localparam int BIT_ITM_LO = 0;
  // Bits software may write in the control/status word
  localparam logic [15:0] CST_WMASK = 16'hB7C3;
  // Reset values
  localparam logic [15:0] CST_RESET = 16'h0000;
  localparam logic [15:0] LIM_RESET = 16'h0000;
  localparam logic [7:0] PW_RESET = 8'h00;
  localparam logic [7:0] CMD_RESET = 8'h00;
  localparam logic [2:0] IRQ_RESET = 3'h0;
  // Command opcodes, upper nibble of a command byte
  localparam logic [3:0] OP_NOP = 4'h0;
  localparam logic [3:0] OP_TRIG = 4'h1;
  localparam logic [3:0] OP_CTRL = 4'h2;
  localparam logic [3:0] OP_WHI = 4'h3;
  localparam logic [3:0] OP_WLO = 4'h4;
  localparam logic [3:0] OP_WTIMER = 4'h5;
  localparam logic [3:0] OP_LOOP = 4'h6;
  // Control step options
  localparam logic [3:0] CTRL_SWT = 4'h0;
  localparam logic [3:0] CTRL_DELAY = 4'h1;
  // Interrupt status bits
  localparam int IRQ_STEP = 0;
  localparam int IRQ_WDT = 1;
  localparam int IRQ_TRIG = 2;
  // Sizes
  localparam int N_LINES = 4;
  localparam int N_CMDS = 4;
  localparam int PW_W = 8;
  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE, ST_EXEC, ST_WAIT_SWT, ST_WAIT_DELAY, ST_WAIT_IN, ST_WAIT_TIMER
  } tsc_state_type;
endpackage

// file: hdl/tsc_trig_if.sv
// Carrier from the sequencer core to the trigger output lines
`timescale 1ns/1ps
`default_nettype none
interface tsc_trig_if;
  logic [tsc_pkg::N_LINES-1:0] fire; // One-cycle command strobe per line
  logic toggle_mode; // Invert instead of pulse
  logic [tsc_pkg::PW_W-1:0] width; // Pulse width minus one
  modport src(output fire, output toggle_mode, output width);
  modport dst(input fire, input toggle_mode, input width);
endinterface
`default_nettype wire

// file: hdl/tsc_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module tsc_sync #(
  parameter int W = 4
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_reg; // First stage, read only by second
  logic [W-1:0] meta_next;
  logic [W-1:0] sync_reg; // Second stage
  logic [W-1:0] sync_next;

  // Next values of both stages
  always_comb begin
    meta_next = clk_en ? async_in : meta_reg;
    sync_next = clk_en ? meta_reg : sync_reg;
  end

  // Stage registers
  always_ff @(posedge clk) begin
    if (reset) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg;
endmodule
`default_nettype wire

// file: hdl/tsc_trigger_line.sv
// One trigger output line: pulse or toggle per trigger command
`timescale 1ns/1ps
`default_nettype none
module tsc_trigger_line #(
  parameter int IDX = 0
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  tsc_trig_if.dst trig,
  output logic line_out
);
  logic line_reg; // Output level
  logic line_next;
  logic [tsc_pkg::PW_W-1:0] cnt_reg; // Remaining pulse cycles
  logic [tsc_pkg::PW_W-1:0] cnt_next;

  // Pulse width counter and level
  always_comb begin
    line_next = line_reg;
    cnt_next = cnt_reg;
    if (!clk_en) begin
      line_next = line_reg;
    end else if (trig.fire[IDX] && trig.toggle_mode) begin
      // RULE3: invert level
      line_next = ~line_reg;
      cnt_next = '0;
    end else if (trig.fire[IDX]) begin
      // RULE4: single pulse
      line_next = 1'b1;
      cnt_next = trig.width;
    end else if (line_reg && !trig.toggle_mode && cnt_reg == '0) begin
      // Pulse over
      line_next = 1'b0;
    end else if (cnt_reg != '0) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  // Line state registers
  always_ff @(posedge clk) begin
    if (reset) begin
      line_reg <= 1'b0;
      cnt_reg <= '0;
    end else begin
      line_reg <= line_next;
      cnt_reg <= cnt_next;
    end
  end

  assign line_out = line_reg;
endmodule
`default_nettype wire

// file: hdl/tsc_trigger_sequencer.sv
// Trigger sequencer control, command engine and Avalon-MM registers
// Summary of operation
// RULE1: Enable bit 15 runs whole sequencer
// RULE2: Idle-stop bit halts sequencer in Idle
// RULE3: Toggle mode inverts selected output line
// RULE4: Otherwise one pulse of programmed width
// RULE5: Writing one triggers, zero does nothing
// RULE6: Only control step command reads trigger
// RULE7: Single-step enable bit selects single-step mode
// RULE8: Single-step is for debugging tools only
// RULE9: Visibility bit makes limit reads show counters; the watchdog limit read always shows wdlim_reg
// RULE10: Start runs commands continuously, clear stops
// RULE11: Hardware sets timeout flag on watchdog expiry
// RULE12: Timing mode bits affect wait commands only
// RULE13: Unused control bits read zero
// RULE14: All control bits reset to zero
// RULE15: Write zero clears timeout, set wins
//
// Local design decisions: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module tsc_trigger_sequencer (
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic idle_mode,
  input wire logic [3:0] trigger_input,
  input wire logic [5:0] avm_address,
  input wire logic avm_read,
  input wire logic avm_write,
  input wire logic [31:0] avm_writedata,
  input wire logic [3:0] avm_byteenable,
  output logic [31:0] avm_readdata,
  output logic avm_waitrequest,
  output logic irq,
  output logic [3:0] trigger_output_line
);
  // Register file state
  logic [15:0] cst_reg; // Control/status, swt bit holds pending trigger
  logic [15:0] cst_next;
  logic [15:0] sdlim_reg; // Step delay limit
  logic [15:0] sdlim_next;
  logic [15:0] clim_reg; // Loop counter limit
  logic [15:0] clim_next;
  logic [15:0] tlim_reg; // Timer limit
  logic [15:0] tlim_next;
  logic [15:0] wdlim_reg; // Watchdog limit, zero disables
  logic [15:0] wdlim_next;
  logic [7:0] pw_reg; // Pulse width field
  logic [7:0] pw_next;
  logic [7:0] cmd_reg [tsc_pkg::N_CMDS]; // Command list
  logic [7:0] cmd_next [tsc_pkg::N_CMDS];
  logic [2:0] istat_reg; // Sticky interrupt status
  logic [2:0] istat_next;
  logic [2:0] imask_reg; // Interrupt mask
  logic [2:0] imask_next;
  logic wait_reg; // Avalon waitrequest
  logic wait_next;
  logic [31:0] rdata_reg; // Avalon read data
  logic [31:0] rdata_next;
  logic irq_reg; // Interrupt level
  logic irq_next;

  // Sequencer state
  tsc_pkg::tsc_state_type state_reg;
  tsc_pkg::tsc_state_type state_next;
  logic [1:0] pc_reg; // Command index
  logic [1:0] pc_next;
  logic [15:0] sd_reg; // Step delay counter
  logic [15:0] sd_next;
  logic [15:0] loop_reg; // Loop counter
  logic [15:0] loop_next;
  logic [15:0] tmr_reg; // Sequencer timer
  logic [15:0] tmr_next;
  logic [15:0] wdt_reg; // Watchdog counter
  logic [15:0] wdt_next;

  // Events from sequencer to register file
  logic step_done; // A command completed
  logic wdt_hit; // Watchdog expired
  logic swt_taken; // Software trigger consumed
  logic ss_stop; // Single step drops start
  logic [tsc_pkg::N_LINES-1:0] fire; // Trigger command strobes
  logic [3:0] in_sync; // Synchronised trigger inputs

  tsc_trig_if trig_bus ();

  // Pin inputs are synchronised before anyone looks at them
  tsc_sync #(.W(4)) u_sync (
    .clk(clk),
    .reset(reset),
    .clk_en(clk_en),
    .async_in(trigger_input),
    .sync_out(in_sync)
  );

  assign trig_bus.fire = fire;
  assign trig_bus.toggle_mode = cst_reg[tsc_pkg::BIT_TOGL];
  assign trig_bus.width = pw_reg;

  // One pulse/toggle generator per output line
  for (genvar g = 0; g < tsc_pkg::N_LINES; g++) begin : g_line
    tsc_trigger_line #(.IDX(g)) u_line (
      .clk(clk),
      .reset(reset),
      .clk_en(clk_en),
      .trig(trig_bus),
      .line_out(trigger_output_line[g])
    );
  end

  // Sequencer next state
  always_comb begin
    logic run;
    logic done;
    logic [7:0] cmd;
    logic match;
    run = 1'b0;
    done = 1'b0;
    cmd = cmd_reg[pc_reg];
    match = 1'b0;
    state_next = state_reg;
    pc_next = pc_reg;
    sd_next = sd_reg;
    loop_next = loop_reg;
    tmr_next = tmr_reg;
    wdt_next = wdt_reg;
    step_done = 1'b0;
    wdt_hit = 1'b0;
    swt_taken = 1'b0;
    ss_stop = 1'b0;
    fire = '0;
    // RULE2: idle stop
    run = clk_en && !(cst_reg[tsc_pkg::BIT_SIDL] && idle_mode);
    if (clk_en && !cst_reg[tsc_pkg::BIT_EN]) begin
      // RULE1: held disabled
      state_next = tsc_pkg::ST_IDLE;
      pc_next = '0;
      sd_next = '0;
      loop_next = '0;
      tmr_next = '0;
      wdt_next = '0;
    end else if (run && !cst_reg[tsc_pkg::BIT_STRT]) begin
      // RULE10: start cleared stops
      state_next = tsc_pkg::ST_IDLE;
    end else if (run) begin
      case (state_reg)
        tsc_pkg::ST_IDLE: begin
          // RULE10: start begins execution
          state_next = tsc_pkg::ST_EXEC;
        end
        tsc_pkg::ST_EXEC: begin
          wdt_next = '0;
          case (cmd[7:4])
            tsc_pkg::OP_TRIG: begin
              fire[cmd[1:0]] = 1'b1;
              done = 1'b1;
            end
            tsc_pkg::OP_CTRL: begin
              sd_next = '0;
              // RULE6: only this option waits on software trigger
              if (cmd[3:0] == tsc_pkg::CTRL_SWT) begin
                state_next = tsc_pkg::ST_WAIT_SWT;
              end else if (cmd[3:0] == tsc_pkg::CTRL_DELAY) begin
                state_next = tsc_pkg::ST_WAIT_DELAY;
              end else begin
                done = 1'b1;
              end
            end
            tsc_pkg::OP_WHI, tsc_pkg::OP_WLO: begin
              state_next = tsc_pkg::ST_WAIT_IN;
            end
            tsc_pkg::OP_WTIMER: begin
              tmr_next = '0;
              state_next = tsc_pkg::ST_WAIT_TIMER;
            end
            tsc_pkg::OP_LOOP: begin
              // Jump back to the first command until the limit is met
              if (loop_reg != clim_reg) begin
                loop_next = loop_reg + 16'h0001;
                pc_next = 2'h3;
              end else begin
                loop_next = '0;
              end
              done = 1'b1;
            end
            default: begin
              done = 1'b1;
            end
          endcase
        end
        tsc_pkg::ST_WAIT_SWT: begin
          if (cst_reg[tsc_pkg::BIT_SWT]) begin
            swt_taken = 1'b1;
            done = 1'b1;
          end
        end
        tsc_pkg::ST_WAIT_DELAY: begin
          if (sd_reg == sdlim_reg) begin
            done = 1'b1;
          end else begin
            sd_next = sd_reg + 16'h0001;
          end
        end
        tsc_pkg::ST_WAIT_IN: begin
          match = (cmd[7:4] == tsc_pkg::OP_WHI) ? in_sync[cmd[1:0]] : !in_sync[cmd[1:0]];
          // RULE12: timing mode bits only here
          if (match && cst_reg[tsc_pkg::BIT_ITM_HI:tsc_pkg::BIT_ITM_LO] == 2'h0) begin
            done = 1'b1;
          end else if (match) begin
            sd_next = '0;
            state_next = tsc_pkg::ST_WAIT_DELAY;
          end
        end
        tsc_pkg::ST_WAIT_TIMER: begin
          if (tmr_reg == tlim_reg) begin
            done = 1'b1;
          end else begin
            tmr_next = tmr_reg + 16'h0001;
          end
        end
        default: begin
          state_next = tsc_pkg::ST_IDLE;
        end
      endcase
      // RULE11: watchdog on any wait state
      if (state_reg != tsc_pkg::ST_IDLE && state_reg != tsc_pkg::ST_EXEC && !done) begin
        if (wdlim_reg != '0 && wdt_reg == wdlim_reg) begin
          wdt_hit = 1'b1;
          done = 1'b1;
        end else begin
          wdt_next = wdt_reg + 16'h0001;
        end
      end
      if (done) begin
        step_done = 1'b1;
        pc_next = pc_next + 2'h1;
        state_next = tsc_pkg::ST_EXEC;
        // RULE7: single step stops after one
        if (cst_reg[tsc_pkg::BIT_SSEN]) begin
          ss_stop = 1'b1;
          state_next = tsc_pkg::ST_IDLE;
        end
      end
    end
  end

  // Sequencer registers
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= tsc_pkg::ST_IDLE;
      pc_reg <= '0;
      sd_reg <= tsc_pkg::LIM_RESET;
      loop_reg <= tsc_pkg::LIM_RESET;
      tmr_reg <= tsc_pkg::LIM_RESET;
      wdt_reg <= tsc_pkg::LIM_RESET;
    end else begin
      state_reg <= state_next;
      pc_reg <= pc_next;
      sd_reg <= sd_next;
      loop_reg <= loop_next;
      tmr_reg <= tmr_next;
      wdt_reg <= wdt_next;
    end
  end

  // Register file and bus slave next state
  always_comb begin
    logic acc;
    logic wr;
    logic [5:0] a;
    logic [31:0] wd;
    logic [31:0] lanes;
    logic [15:0] ncst;
    acc = (avm_read || avm_write) && wait_reg && clk_en;
    wr = avm_write && !wait_reg && clk_en;
    a = {avm_address[5:2], 2'b00};
    lanes = {{8{avm_byteenable[3]}}, {8{avm_byteenable[2]}}, {8{avm_byteenable[1]}},
             {8{avm_byteenable[0]}}};
    wd = avm_writedata & lanes;
    ncst = cst_reg;
    cst_next = cst_reg;
    // Consumed trigger drops unless rewritten
    cst_next[tsc_pkg::BIT_SWT] = cst_reg[tsc_pkg::BIT_SWT] && !swt_taken;
    sdlim_next = sdlim_reg;
    clim_next = clim_reg;
    tlim_next = tlim_reg;
    wdlim_next = wdlim_reg;
    pw_next = pw_reg;
    cmd_next = cmd_reg;
    istat_next = istat_reg;
    imask_next = imask_reg;
    rdata_next = rdata_reg;
    wait_next = wait_reg;
    if (clk_en) begin
      // One wait cycle, then one cycle with waitrequest low
      wait_next = !acc;
    end
    if (acc && avm_read) begin
      rdata_next = 32'h0000_0000;
      if (a == tsc_pkg::OFS_CST) begin
        // RULE13: unused bits read zero
        rdata_next[15:0] = cst_reg & tsc_pkg::CST_WMASK;
      end else if (a == tsc_pkg::OFS_SDLIM) begin
        // RULE9: live or written value
        rdata_next[15:0] = cst_reg[tsc_pkg::BIT_VIS] ? sd_reg : sdlim_reg;
      end else if (a == tsc_pkg::OFS_CLIM) begin
        rdata_next[15:0] = cst_reg[tsc_pkg::BIT_VIS] ? loop_reg : clim_reg;
      end else if (a == tsc_pkg::OFS_TLIM) begin
        rdata_next[15:0] = cst_reg[tsc_pkg::BIT_VIS] ? tmr_reg : tlim_reg;
      end else if (a == tsc_pkg::OFS_PWIDTH) begin
        rdata_next[7:0] = pw_reg;
      end else if (a == tsc_pkg::OFS_CMD) begin
        rdata_next = {cmd_reg[3], cmd_reg[2], cmd_reg[1], cmd_reg[0]};
      end else if (a == tsc_pkg::OFS_ISTAT) begin
        rdata_next[2:0] = istat_reg;
      end else if (a == tsc_pkg::OFS_IMASK) begin
        rdata_next[2:0] = imask_reg;
      end else if (a == tsc_pkg::OFS_WDLIM) begin
        rdata_next[15:0] = wdlim_reg;
      end
    end
    if (wr) begin
      if (a == tsc_pkg::OFS_CST) begin
        ncst = (cst_reg & ~lanes[15:0]) | wd[15:0];
        // RULE13: unused bits ignore writes
        cst_next = ncst & tsc_pkg::CST_WMASK;
        // RULE5: writing zero leaves trigger pending
        cst_next[tsc_pkg::BIT_SWT] = (cst_reg[tsc_pkg::BIT_SWT] && !swt_taken) ||
                                     wd[tsc_pkg::BIT_SWT];
        // RULE15: only a zero write clears, one is ignored
        cst_next[tsc_pkg::BIT_WDTO] = cst_reg[tsc_pkg::BIT_WDTO] && ncst[tsc_pkg::BIT_WDTO];
      end else if (a == tsc_pkg::OFS_SDLIM) begin
        sdlim_next = (sdlim_reg & ~lanes[15:0]) | wd[15:0];
      end else if (a == tsc_pkg::OFS_CLIM) begin
        clim_next = (clim_reg & ~lanes[15:0]) | wd[15:0];
      end else if (a == tsc_pkg::OFS_TLIM) begin
        tlim_next = (tlim_reg & ~lanes[15:0]) | wd[15:0];
      end else if (a == tsc_pkg::OFS_PWIDTH) begin
        pw_next = avm_byteenable[0] ? avm_writedata[7:0] : pw_reg;
      end else if (a == tsc_pkg::OFS_CMD) begin
        for (int i = 0; i < tsc_pkg::N_CMDS; i++) begin
          cmd_next[i] = avm_byteenable[i] ? avm_writedata[i*8 +: 8] : cmd_reg[i];
        end
      end else if (a == tsc_pkg::OFS_ISTAT) begin
        // Write one to clear
        istat_next = istat_reg & ~wd[2:0];
      end else if (a == tsc_pkg::OFS_IMASK) begin
        imask_next = avm_byteenable[0] ? avm_writedata[2:0] : imask_reg;
      end else if (a == tsc_pkg::OFS_WDLIM) begin
        wdlim_next = (wdlim_reg & ~lanes[15:0]) | wd[15:0];
      end
    end
    // Hardware events win over software writes
    if (ss_stop) begin
      cst_next[tsc_pkg::BIT_STRT] = 1'b0;
    end
    // RULE11: set on expiry
    // RULE15: set wins over clear
    if (wdt_hit) begin
      cst_next[tsc_pkg::BIT_WDTO] = 1'b1;
    end
    istat_next[tsc_pkg::IRQ_STEP] = istat_next[tsc_pkg::IRQ_STEP] | step_done;
    istat_next[tsc_pkg::IRQ_WDT] = istat_next[tsc_pkg::IRQ_WDT] | wdt_hit;
    istat_next[tsc_pkg::IRQ_TRIG] = istat_next[tsc_pkg::IRQ_TRIG] | (|fire);
    irq_next = clk_en ? |(istat_next & imask_next) : irq_reg;
  end

  // Register file flops
  always_ff @(posedge clk) begin
    if (reset) begin
      // RULE14: everything but waitrequest starts at zero
      cst_reg <= tsc_pkg::CST_RESET;
      sdlim_reg <= tsc_pkg::LIM_RESET;
      clim_reg <= tsc_pkg::LIM_RESET;
      tlim_reg <= tsc_pkg::LIM_RESET;
      wdlim_reg <= tsc_pkg::LIM_RESET;
      pw_reg <= tsc_pkg::PW_RESET;
      for (int i = 0; i < tsc_pkg::N_CMDS; i++) begin
        cmd_reg[i] <= tsc_pkg::CMD_RESET;
      end
      istat_reg <= tsc_pkg::IRQ_RESET;
      imask_reg <= tsc_pkg::IRQ_RESET;
      wait_reg <= 1'b1;
      rdata_reg <= 32'h0000_0000;
      irq_reg <= 1'b0;
    end else begin
      cst_reg <= cst_next;
      sdlim_reg <= sdlim_next;
      clim_reg <= clim_next;
      tlim_reg <= tlim_next;
      wdlim_reg <= wdlim_next;
      pw_reg <= pw_next;
      cmd_reg <= cmd_next;
      istat_reg <= istat_next;
      imask_reg <= imask_next;
      wait_reg <= wait_next;
      rdata_reg <= rdata_next;
      irq_reg <= irq_next;
    end
  end

  assign avm_readdata = rdata_reg;
  assign avm_waitrequest = wait_reg;
  assign irq = irq_reg;
endmodule
`default_nettype wire

// file: verification/tsc_control_monitor.sv
// Port-level checker of the trigger sequencer control block
`timescale 1ns/1ps
`default_nettype none
module tsc_control_monitor (
  input wire logic clk,
  input wire logic reset,
  input wire logic [5:0] avm_address,
  input wire logic avm_read,
  input wire logic avm_write,
  input wire logic [31:0] avm_writedata,
  input wire logic [3:0] avm_byteenable,
  input wire logic [31:0] avm_readdata,
  input wire logic avm_waitrequest,
  input wire logic irq,
  input wire logic [3:0] trigger_output_line
);
  logic wr_done; // Full-word write taken at this edge
  logic tog_reg; // Shadow of toggle mode
  logic en_reg; // Shadow of enable
  logic [7:0] pw_reg; // Shadow of pulse width
  logic [2:0] mask_reg; // Shadow of irq mask
  logic [8:0] hi_cnt_reg; // High time of line 0 so far
  logic [1:0] dis_cnt_reg; // Cycles spent disabled, saturating
  assign wr_done = avm_write && !avm_waitrequest && (avm_byteenable == 4'hF);
  // Shadows follow accepted writes only; partial lanes are not modelled
  always_ff @(posedge clk) begin
    if (reset) begin
      tog_reg <= 1'b0;
      en_reg <= 1'b0;
      pw_reg <= 8'h00;
      mask_reg <= 3'h0;
      hi_cnt_reg <= 9'h000;
      dis_cnt_reg <= 2'h0;
    end else begin
      if (wr_done && avm_address[5:2] == tsc_pkg::OFS_CST[5:2]) begin
        tog_reg <= avm_writedata[tsc_pkg::BIT_TOGL];
        en_reg <= avm_writedata[tsc_pkg::BIT_EN];
      end
      if (wr_done && avm_address[5:2] == tsc_pkg::OFS_PWIDTH[5:2]) pw_reg <= avm_writedata[7:0];
      if (wr_done && avm_address[5:2] == tsc_pkg::OFS_IMASK[5:2]) mask_reg <= avm_writedata[2:0];
      hi_cnt_reg <= trigger_output_line[0] ? hi_cnt_reg + 9'h001 : 9'h000;
      dis_cnt_reg <= en_reg ? 2'h0 : ((dis_cnt_reg == 2'h3) ? 2'h3 : dis_cnt_reg + 2'h1);
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Read answer of the control/status word
  sequence s_cst_rd;
    avm_read && !avm_waitrequest && avm_address[5:2] == tsc_pkg::OFS_CST[5:2];
  endsequence
  // Read answer beyond the last register
  sequence s_far_rd;
    avm_read && !avm_waitrequest && avm_address[5:2] > tsc_pkg::OFS_WDLIM[5:2];
  endsequence
  property p_ans_next;
    (avm_read || avm_write) && avm_waitrequest |=> !avm_waitrequest;
  endproperty
  property p_ans_once;
    !avm_waitrequest |=> avm_waitrequest;
  endproperty
  property p_no_spont;
    $fell(avm_waitrequest) |-> $past(avm_read) || $past(avm_write);
  endproperty
  property p_cst_unused;
    s_cst_rd |-> avm_readdata[31:16] == 16'h0000 && !avm_readdata[14] && !avm_readdata[11]
      && avm_readdata[5:2] == 4'h0;
  endproperty
  property p_unmapped;
    s_far_rd |-> avm_readdata == 32'h00000000;
  endproperty
  property p_rd_hold;
    avm_waitrequest && $past(avm_waitrequest) |-> $stable(avm_readdata);
  endproperty
  property p_pulse_width;
    $fell(trigger_output_line[0]) && !tog_reg |-> hi_cnt_reg == {1'b0, pw_reg} + 9'h001;
  endproperty
  property p_irq_masked;
    mask_reg == 3'h0 && $stable(mask_reg) |-> !irq;
  endproperty
  property p_dis_hold;
    dis_cnt_reg == 2'h3 |-> $stable(trigger_output_line);
  endproperty
  a_ans_next: assert property (p_ans_next) else $error("no answer after one wait cycle");
  a_ans_once: assert property (p_ans_once) else $error("waitrequest low for two cycles");
  a_no_spont: assert property (p_no_spont) else $error("answer without request");
  a_cst_unused: assert property (p_cst_unused) else $error("unused bit reads one");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved while idle");
  a_pulse_width: assert property (p_pulse_width) else $error("pulse width wrong");
  a_irq_masked: assert property (p_irq_masked) else $error("irq high while masked");
  a_dis_hold: assert property (p_dis_hold) else $error("lines move while disabled");
endmodule
bind tsc_trigger_sequencer tsc_control_monitor i_mon(.clk(clk), .reset(reset),
  .avm_address(avm_address), .avm_read(avm_read), .avm_write(avm_write),
  .avm_writedata(avm_writedata), .avm_byteenable(avm_byteenable),
  .avm_readdata(avm_readdata), .avm_waitrequest(avm_waitrequest), .irq(irq),
  .trigger_output_line(trigger_output_line));
`default_nettype wire

// file: verification/tb_trigger_sequencer_control.sv
// Self-checking bench of the trigger sequencer control block
`timescale 1ns/1ps
`default_nettype none
module tb_trigger_sequencer_control;
  logic clk = 1'b0; // System clock, 100 ns
  logic reset = 1'b1; // Synchronous reset
  logic idle_mode = 1'b0; // Device Idle indication
  logic [3:0] trigger_input = 4'h0; // Kept low so waits never match
  logic [5:0] avm_address = 6'h00;
  logic avm_read = 1'b0;
  logic avm_write = 1'b0;
  logic [31:0] avm_writedata = 32'h0;
  logic [31:0] avm_readdata;
  logic avm_waitrequest;
  logic irq;
  logic [3:0] trigger_output_line;
  int n_fail = 0; // Mismatches
  int tests_run = 0; // Comparisons
  int n; // Counted rises or width
  localparam logic [5:0] cst = tsc_pkg::OFS_CST; // Control word offset
  logic [31:0] seed = 32'h09C5EE67; // Random state
  logic [31:0] rd; // Last read answer
  always #50 clk = ~clk;
  // Lanes always full, clock always enabled
  tsc_trigger_sequencer i_dut(.clk(clk), .reset(reset), .clk_en(1'b1), .idle_mode(idle_mode),
    .trigger_input(trigger_input), .avm_address(avm_address), .avm_read(avm_read),
    .avm_write(avm_write), .avm_writedata(avm_writedata), .avm_byteenable(4'hF),
    .avm_readdata(avm_readdata), .avm_waitrequest(avm_waitrequest), .irq(irq),
    .trigger_output_line(trigger_output_line));
  // Shift register for repeatable values
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // One bus access; held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    avm_address <= a;
    avm_writedata <= d;
    avm_write <= wr;
    avm_read <= !wr;
    do @(posedge clk); while (avm_waitrequest !== 1'b0);
    rd = avm_readdata;
    avm_write <= 1'b0;
    avm_read <= 1'b0;
  endtask
  // Register write
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  // Register read and compare
  task automatic rdc(input logic [5:0] a, input string name, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(name, rd, exp);
  endtask
  // Rising edges of line 0 over a span
  task automatic rises(input int cyc, output int cnt);
    logic p;
    cnt = 0;
    p = trigger_output_line[0];
    repeat (cyc) begin
      @(posedge clk);
      if (trigger_output_line[0] === 1'b1 && p === 1'b0) cnt++;
      p = trigger_output_line[0];
    end
  endtask
  // High time of the next pulse on line 0
  task automatic width(output int w);
    w = 0;
    repeat (60) if (trigger_output_line[0] !== 1'b1) @(posedge clk);
    while (trigger_output_line[0] === 1'b1 && w < 300) begin
      @(posedge clk);
      w++;
    end
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Hang guard, well beyond the run length
  initial begin
    repeat (6000) @(posedge clk);
    n_fail++;
    give_verdict();
  end
  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    rdc(cst, "cst reset", 32'h0);
    chk("irq reset", irq, 32'h0);
    wr(cst, 32'h483C);
    rdc(cst, "cst unused", 32'h0);
    // Random control words with enable off; trigger and flag kept clear
    // single step only while stopped
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      wr(cst, seed & 32'hFFFF3383);
      rdc(cst, "cst rw", seed & 32'h3383);
    end
    wr(cst, 32'h0);
    // Limits read back as written while visibility is off
    for (int k = 1; k < 4; k++) begin
      seed = lfsr(seed);
      wr(6'(k * 4), seed);
      rdc(6'(k * 4), "limit", seed & 32'hFFFF);
    end
    wr(6'h24, seed);
    rdc(6'h24, "unmapped", 32'h0);
    seed = lfsr(seed);
    wr(tsc_pkg::OFS_PWIDTH, 32'(seed[2:0]));
    wr(tsc_pkg::OFS_CMD, 32'h20202010);
    wr(cst, 32'h80);
    rises(40, n);
    chk("disabled", n, 32'h0);
    idle_mode <= 1'b1;
    wr(cst, 32'hA080);
    rises(40, n);
    chk("idle stop", n, 32'h0);
    idle_mode <= 1'b0;
    width(n);
    chk("pulse width", n, 32'(seed[2:0]) + 32'h1);
    rises(40, n);
    chk("held at wait", n, 32'h0);
    wr(cst, 32'hA080);
    rises(20, n);
    chk("trigger zero", n, 32'h0);
    repeat (3) wr(cst, 32'hA480);
    rises(40, n);
    chk("trigger one", n, 32'h1);
    // Watchdog expiry while waiting on a silent input
    wr(cst, 32'h0);
    wr(tsc_pkg::OFS_WDLIM, 32'h14);
    wr(tsc_pkg::OFS_CMD, 32'h30303030);
    wr(cst, 32'h8080);
    repeat (60) @(posedge clk);
    rdc(cst, "timeout flag", 32'h80C0);
    chk("irq masked", irq, 32'h0);
    wr(tsc_pkg::OFS_IMASK, 32'h2);
    repeat (2) @(posedge clk);
    chk("irq raised", irq, 32'h1);
    // Stop first so no new expiry races the clear
    wr(cst, 32'h40);
    wr(cst, 32'h0);
    rdc(cst, "flag cleared", 32'h0);
    rdc(tsc_pkg::OFS_ISTAT, "status", 32'h7);
    wr(tsc_pkg::OFS_ISTAT, 32'h7);
    repeat (2) @(posedge clk);
    chk("irq cleared", irq, 32'h0);
    // Toggle mode: each trigger command inverts the line
    wr(tsc_pkg::OFS_CMD, 32'h20202010);
    wr(cst, 32'h9080);
    rises(40, n);
    chk("toggle high", trigger_output_line[0], 32'h1);
    repeat (3) wr(cst, 32'h9480);
    rises(40, n);
    chk("toggle low", trigger_output_line[0], 32'h0);
    give_verdict();
  end
endmodule
`default_nettype wire
